// file: rcil_cfg.svh
// Offsets, field positions, reset values and vectors of the reset block
`ifndef RCIL_CFG_SVH
`define RCIL_CFG_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define RCIL_IDX_STATUS 6'h03
`define RCIL_IDX_PORT6  6'h06
`define RCIL_IDX_PORT7  6'h07
`define RCIL_IDX_GEN8   6'h08
`define RCIL_IDX_WAKE   6'h0B
`define RCIL_IDX_SLPWDT 6'h0E
`define RCIL_IDX_MASK   6'h0F
`define RCIL_IDX_ISTAT  6'h3F
// ==========================================================
// Field positions
`define RCIL_BIT_TIMER  0
`define RCIL_BIT_EXT    3
`define RCIL_BIT_ODE    6
`define RCIL_BIT_WATCHDOG_ENABLE_BIT   5
`define RCIL_BIT_SLEEP_CONTROL_BIT   4
`define RCIL_BIT_GWUE   0
`define RCIL_BIT_TOUT   4
`define RCIL_BIT_PDWN   3
// ==========================================================
// Reset values and writable masks
`define RCIL_RST_GEN8   8'h00
`define RCIL_RST_WAKE   8'hFF
`define RCIL_RST_SLPWDT 8'h31
`define RCIL_RST_MASK   8'h00
`define RCIL_RST_PORT   8'h00
`define RCIL_WR_SLPWDT  8'h79
`define RCIL_WR_MASK    8'h09
// ==========================================================
// Fetch vectors
`define RCIL_VEC_IRQ    10'h001
`define RCIL_VEC_SOFT   10'h002
`endif

// file: rcil_core_model.sv
// Core model that takes interrupt vectors
`timescale 1ns/1ps
`default_nettype none
module rcil_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Vector handshake
    input  wire logic       vectorReq,
    input  wire logic [9:0] vectorAddr,
    input  wire logic       slowAck,
    output var  logic       vectorAck,
    output var  logic [9:0] lastVec
);
    // ==============================
    // Vector fetch
    int wt;    // Cycles waited on a request
    // Acknowledge after one cycle, or five when slow
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wt        <= 0;
            vectorAck <= 1'b0;
            lastVec   <= 10'h000;
        end else if (vectorReq && !vectorAck) begin
            wt <= wt + 1;
            if (wt >= (slowAck ? 4 : 0)) begin
                vectorAck <= 1'b1;
                lastVec   <= vectorAddr;
            end
        end else begin
            wt        <= 0;
            vectorAck <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: rcil_flag.sv
// Sticky event flag with software clear and soft-reset clear
`timescale 1ns/1ps
`default_nettype none
module rcil_flag (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Controls
    input  wire logic setEvt,
    input  wire logic clrEvt,
    input  wire logic rstClr,
    // Flag
    output var  logic flag_ff
);
    // Soft reset clears, then a new event beats a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else if (rstClr) begin
            flag_ff <= 1'b0;
        end else if (setEvt) begin
            flag_ff <= 1'b1;
        end else if (clrEvt) begin
            flag_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: rcil_pkg.sv
// Types shared by the reset cause and interrupt logic
package rcil_pkg;
    // Core power state, one-hot
    typedef enum logic [2:0] {
        RCIL_OPER   = 3'b001,
        RCIL_SLEEP1 = 3'b010,
        RCIL_SLEEP2 = 3'b100
    } rcil_mode_type;
endpackage

// file: rcil_tb_top.sv
// Self-checking bench of the reset cause and interrupt block
`timescale 1ns/1ps
`default_nettype none
module rcil_tb_top;
    // ==============================
    // Signals
    localparam int I_EN = 0, I_DIS = 1, I_RET = 2, I_CLR = 3, I_SLP = 4;
    localparam int I_SOFT = 5, I_TMR = 6, I_EXT = 7, I_DOG = 8;
    logic        clk, rst, psel, penable, pwrite, resetPinN, slowAck;
    logic [7:0]  paddr, portChange, p6, p7, d;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0]  evs;    // Core strobes by index above
    logic        pready, pslverr, err, vAck, vReq, gie, tF, pF;
    logic        cRst, stall, resume, wdRun;
    logic [9:0]  vAddr, lastVec;
    logic [1:0]  irq, tp;
    int          n_errors, compares, seed, nRes;
    // ==============================
    // Design and core model
    rcil_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .resetPinN(resetPinN),
        .wdtTimeout(evs[I_DOG]), .instrEni(evs[I_EN]),
        .instrDisi(evs[I_DIS]), .instrReti(evs[I_RET]),
        .instrWdtc(evs[I_CLR]), .instrSleep(evs[I_SLP]),
        .instrSoftInt(evs[I_SOFT]), .vectorAck(vAck),
        .timerOverflow(evs[I_TMR]), .extIrqEvent(evs[I_EXT]),
        .portChange(portChange), .coreReset_ff(cRst), .coreStall_ff(stall),
        .resumeNext_ff(resume), .vectorReq_ff(vReq), .vectorAddr_ff(vAddr),
        .globalIrqEn_ff(gie), .irqRequest_ff(irq), .timeoutFlag_ff(tF),
        .powerDownFlag_ff(pF), .watchdogRun_ff(wdRun), .port6Data_ff(p6),
        .port7Data_ff(p7));
    rcil_core_model i_core (.clk(clk), .rst(rst), .vectorReq(vReq),
        .vectorAddr(vAddr), .slowAck(slowAck), .vectorAck(vAck),
        .lastVec(lastVec));
    // ==============================
    // Expected flags after a reset cause; m mode, c 0 pin 1 watchdog
    function automatic logic [1:0] expTP(int m, int c, logic [1:0] p);
        if (c == 0) return (m == 1) ? 2'b10 : p;
        return (m == 1) ? 2'b00 : {1'b0, p[0]};
    endfunction
    // Compare one value and count it
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Print counts and verdict, then stop
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One bus transfer, held until ready is seen
    task automatic apb(input logic w, input logic [5:0] i,
                       input logic [7:0] v);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {i, 2'b00};
        pwdata <= {24'h000000, v};
        @(posedge clk);
        penable <= 1'b1;
        // Wait as long as it takes; the hang guard ends a lost answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read a register and compare it
    task automatic rdChk(input logic [5:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk({err, rd}, {9'h000, 16'h0000, e});
    endtask
    // Pulse a strobe and/or pin changes for one cycle
    task automatic fire(input int b, input logic [7:0] pc);
        @(posedge clk);
        if (b >= 0) evs[b] <= 1'b1;
        portChange <= pc;
        @(posedge clk);
        evs        <= 9'h000;
        portChange <= 8'h00;
        repeat (3) @(posedge clk);
    endtask
    // Low then high pulse on the reset pin
    task automatic pinRst;
        @(posedge clk);
        resetPinN <= 1'b0;
        repeat (2) @(posedge clk);
        resetPinN <= 1'b1;
        repeat (2) @(posedge clk);
        chk(cRst, 1'b1);
        @(posedge clk);
    endtask
    // ==============================
    // Clock, resume counter and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (resume === 1'b1) nRes <= nRes + 1;
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end
    // ==============================
    // Test sequence
    initial begin
        {psel, penable, pwrite, slowAck, resetPinN} = 5'h01;
        {paddr, portChange, pwdata, evs} = '0;
        {n_errors, compares, nRes} = '0;
        seed = 32'h1B57;
        rst  = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdChk(6'h0B, 8'hFF);
        rdChk(6'h0E, 8'h31);
        rdChk(6'h03, 8'h18);
        apb(1'b0, 6'h10, 8'h00);
        chk({err, rd}, {1'b1, 32'h0});
        repeat (4) begin
            d = 8'($random(seed));
            apb(1'b1, 6'h06, d);
            @(posedge clk);
            chk(p6, d);
            apb(1'b1, 6'h07, d ^ 8'h5A);
            @(posedge clk);
            chk(p7, d ^ 8'h5A);
            apb(1'b1, 6'h0F, d);
            rdChk(6'h0F, d & 8'h09);
        end
        $display("Test registers done");
        // Cause table over every mode and both reset causes
        for (int m = 0; m < 3; m++) begin
            for (int c = 0; c < 2; c++) begin
                tp = 2'b11;
                if ($random(seed) & 1) begin
                    fire(I_SLP, 8'h00);
                    pinRst();
                    tp = 2'b10;
                end else begin
                    fire(I_CLR, 8'h00);
                end
                chk({tF, pF}, tp);
                if (m == 1) begin
                    fire(I_SLP, 8'h00);
                    tp = 2'b10;
                end else if (m == 2) begin
                    apb(1'b1, 6'h0E, 8'h20);
                end
                if (m > 0) begin
                    d = 8'($random(seed));
                    fire(-1, d);
                    chk({stall, tF, pF}, {1'b1, tp});
                end
                if (c == 0) pinRst();
                else fire(I_DOG, 8'h00);
                chk({stall, tF, pF}, {1'b0, expTP(m, c, tp)});
            end
        end
        $display("Test reset causes done");
        // Pin-change wake from sleep two keeps state
        fire(I_SLP, 8'h00);
        pinRst();
        fire(I_DOG, 8'h00);
        chk({tF, pF}, 2'b00);
        d = 8'($random(seed));
        apb(1'b1, 6'h06, d);
        apb(1'b1, 6'h0B, 8'hFE);
        apb(1'b1, 6'h0F, 8'h09);
        fire(I_TMR, 8'h00);
        apb(1'b1, 6'h0E, 8'h40);
        fire(-1, d & 8'hFE);
        chk({stall, wdRun}, 2'b10);
        fire(-1, 8'h01);
        chk({stall, tF, pF}, 3'b000);
        chk(nRes, 1);
        chk({p6, wdRun}, {d, 1'b1});
        rdChk(6'h0E, 8'h70);
        rdChk(6'h0B, 8'hFE);
        rdChk(6'h3F, 8'h01);
        $display("Test pin-change wake done");
        // Interrupt flags, masks and vectors
        pinRst();
        fire(I_TMR, 8'h00);
        rdChk(6'h3F, 8'h01);
        chk(irq, 2'b00);
        apb(1'b1, 6'h0F, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 2'b01);
        d = 8'($random(seed));
        slowAck <= d[0];
        fire(I_EN, 8'h00);
        repeat (8) @(posedge clk);
        chk({lastVec, gie}, {10'h001, 1'b0});
        apb(1'b1, 6'h3F, 8'h00);
        fire(I_RET, 8'h00);
        chk({gie, vReq}, 2'b10);
        fire(I_DIS, 8'h00);
        chk(gie, 1'b0);
        fire(I_EN, 8'h00);
        chk(gie, 1'b1);
        fire(I_SOFT, 8'h00);
        repeat (8) @(posedge clk);
        chk({lastVec, gie}, {10'h002, 1'b0});
        fire(I_EXT, 8'h00);
        rdChk(6'h3F, 8'h08);
        apb(1'b1, 6'h0F, 8'h08);
        repeat (2) @(posedge clk);
        chk(irq, 2'b10);
        $display("Test interrupts done");
        results();
    end
endmodule
`default_nettype wire

// file: rcil_top.sv
// Reset cause tracking and interrupt vectoring with APB registers
`include "rcil_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Power-on, pin pulse or watchdog reset core
// - Clear-watchdog sets both; sleep sets T clears P
// - Pin reset when running keeps both flags
// - Pin wake from sleep one: T1 P0
// - Pin wake from sleep two keeps flags
// - Watchdog when running: T0, P kept
// - Watchdog wake from sleep one: both 0
// - Watchdog wake from sleep two: T0, P kept
// - Pin-change wake keeps both flags
// - Pin-change wake keeps state, forces WATCHDOG_ENABLE_BIT SLEEP_CONTROL_BIT
// - Resume strobe one cycle after pin-change wake
// - Timer overflow flag bit0, external bit3
// - Flags set regardless of masks
// - Request is flag AND mask
// - Enable and disable instructions steer global
// - Enabled interrupt fetches from 001H
// - Return from interrupt re-enables global
// - Software interrupt fetches from 002H
// - Sleep-two wake turns watchdog on
module rcil_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Reset sources
    input  wire logic        resetPinN,
    input  wire logic        wdtTimeout,
    // Core instruction strobes
    input  wire logic        instrEni,
    input  wire logic        instrDisi,
    input  wire logic        instrReti,
    input  wire logic        instrWdtc,
    input  wire logic        instrSleep,
    input  wire logic        instrSoftInt,
    input  wire logic        vectorAck,
    // Events
    input  wire logic        timerOverflow,
    input  wire logic        extIrqEvent,
    input  wire logic [7:0]  portChange,
    // Core control
    output var  logic        coreReset_ff,
    output var  logic        coreStall_ff,
    output var  logic        resumeNext_ff,
    output var  logic        vectorReq_ff,
    output var  logic [9:0]  vectorAddr_ff,
    output var  logic        globalIrqEn_ff,
    output var  logic [1:0]  irqRequest_ff,
    // Status and pins
    output var  logic        timeoutFlag_ff,
    output var  logic        powerDownFlag_ff,
    output var  logic        watchdogRun_ff,
    output var  logic [7:0]  port6Data_ff,
    output var  logic [7:0]  port7Data_ff
);
    // ==========================================================
    // Declarations
    rcil_pkg::rcil_mode_type mode_ff;      // Power state
    rcil_pkg::rcil_mode_type nxt_mode;     // Next power state
    logic       pinLow_ff;                 // Reset pin seen low
    logic       pinEvt;                    // Pin pulse completed
    logic       sysReset;                  // Pin or watchdog reset
    logic       wake2;                     // Pin-change wake
    logic [7:0] gen8_ff;                   // General register
    logic [7:0] wakeEnN_ff;                // Per-pin wake enables
    logic [7:0] slpWdt_ff;                 // Sleep/watchdog control
    logic [7:0] mask_ff;                   // Interrupt mask
    logic [1:0] flag;                      // Interrupt flags
    logic [1:0] evt;                       // Interrupt events
    logic [1:0] clr;                       // Software clears
    logic [1:0] pending;                   // Flag AND mask
    logic [5:0] idx;                       // Register index
    logic       wrEn;                      // Write accepted
    logic       enterSleep2;               // Sleep-control cleared
    logic [7:0] istat;                     // Status byte view
    logic [7:0] rdByte;                    // Read mux
    logic       hit;                       // Mapped address

    assign idx    = paddr[7:2];
    assign wrEn   = psel & penable & pready & pwrite;
    assign pinEvt = pinLow_ff & resetPinN;
    assign sysReset = pinEvt | wdtTimeout;
    // only sleep two wakes on pin change
    assign wake2 = (mode_ff == rcil_pkg::RCIL_SLEEP2)
                 & ~slpWdt_ff[`RCIL_BIT_GWUE]
                 & |(portChange & ~wakeEnN_ff);
    assign enterSleep2 = wrEn & (idx == `RCIL_IDX_SLPWDT)
                       & ~pwdata[`RCIL_BIT_SLEEP_CONTROL_BIT];
    assign evt = {extIrqEvent, timerOverflow};

    // ==========================================================
    // Reset pin pulse detector
    // Catches the low phase; the release completes the pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinLow_ff <= 1'b0;
        end else begin
            pinLow_ff <= ~resetPinN;
        end
    end

    // Core reset strobe, held during power-on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coreReset_ff <= 1'b1;
        end else begin
            coreReset_ff <= sysReset;
        end
    end

    // ==========================================================
    // Power state machine
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            rcil_pkg::RCIL_OPER: begin
                if (sysReset) begin
                    nxt_mode = rcil_pkg::RCIL_OPER;
                end else if (instrSleep) begin
                    nxt_mode = rcil_pkg::RCIL_SLEEP1;
                end else if (enterSleep2) begin
                    nxt_mode = rcil_pkg::RCIL_SLEEP2;
                end
            end
            rcil_pkg::RCIL_SLEEP1: begin
                if (sysReset) begin
                    nxt_mode = rcil_pkg::RCIL_OPER;
                end
            end
            rcil_pkg::RCIL_SLEEP2: begin
                // halt left by any wake source
                if (sysReset | wake2) begin
                    nxt_mode = rcil_pkg::RCIL_OPER;
                end
            end
            default: begin
                nxt_mode = rcil_pkg::RCIL_OPER;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_ff <= rcil_pkg::RCIL_OPER;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // Core stall while asleep
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coreStall_ff <= 1'b0;
        end else begin
            coreStall_ff <= (nxt_mode != rcil_pkg::RCIL_OPER);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resumeNext_ff <= 1'b0;
        end else begin
            resumeNext_ff <= wake2 & ~sysReset;
        end
    end

    // ==========================================================
    // Time-out and power-down flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeoutFlag_ff   <= 1'b1;
            powerDownFlag_ff <= 1'b1;
        end else if (pinEvt) begin
            if (mode_ff == rcil_pkg::RCIL_SLEEP1) begin
                timeoutFlag_ff   <= 1'b1;
                powerDownFlag_ff <= 1'b0;
            end
        end else if (wdtTimeout) begin
            timeoutFlag_ff <= 1'b0;
            if (mode_ff == rcil_pkg::RCIL_SLEEP1) begin
                powerDownFlag_ff <= 1'b0;
            end
        end else if (instrWdtc) begin
            timeoutFlag_ff   <= 1'b1;
            powerDownFlag_ff <= 1'b1;
        end else if (instrSleep & (mode_ff == rcil_pkg::RCIL_OPER)) begin
            timeoutFlag_ff   <= 1'b1;
            powerDownFlag_ff <= 1'b0;
        end
        // pin-change wake leaves both flags alone
    end

    // ==========================================================
    // Port data and general register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port6Data_ff <= `RCIL_RST_PORT;
            port7Data_ff <= `RCIL_RST_PORT;
        end else if (wrEn & (idx == `RCIL_IDX_PORT6)) begin
            port6Data_ff <= pwdata[7:0];
        end else if (wrEn & (idx == `RCIL_IDX_PORT7)) begin
            port7Data_ff <= pwdata[7:0];
        end
    end

    // General register cleared by any reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gen8_ff <= `RCIL_RST_GEN8;
        end else if (sysReset) begin
            gen8_ff <= `RCIL_RST_GEN8;
        end else if (wrEn & (idx == `RCIL_IDX_GEN8)) begin
            gen8_ff <= pwdata[7:0];
        end
    end

    // Wake enables and interrupt mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wakeEnN_ff <= `RCIL_RST_WAKE;
            mask_ff    <= `RCIL_RST_MASK;
        end else if (sysReset) begin
            wakeEnN_ff <= `RCIL_RST_WAKE;
            mask_ff    <= `RCIL_RST_MASK;
        end else if (wrEn & (idx == `RCIL_IDX_WAKE)) begin
            wakeEnN_ff <= pwdata[7:0];
        end else if (wrEn & (idx == `RCIL_IDX_MASK)) begin
            mask_ff <= pwdata[7:0] & `RCIL_WR_MASK;
        end
    end

    // Sleep/watchdog control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slpWdt_ff <= `RCIL_RST_SLPWDT;
        end else if (sysReset) begin
            slpWdt_ff <= `RCIL_RST_SLPWDT;
        end else if (wake2) begin
            slpWdt_ff[`RCIL_BIT_WATCHDOG_ENABLE_BIT] <= 1'b1;
            slpWdt_ff[`RCIL_BIT_SLEEP_CONTROL_BIT] <= 1'b1;
        end else if (wrEn & (idx == `RCIL_IDX_SLPWDT)) begin
            slpWdt_ff <= pwdata[7:0] & `RCIL_WR_SLPWDT;
        end
    end

    // Watchdog run output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdogRun_ff <= 1'b1;
        end else begin
            watchdogRun_ff <= slpWdt_ff[`RCIL_BIT_WATCHDOG_ENABLE_BIT];
        end
    end

    // ==========================================================
    // Interrupt flags, one per source
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gFlag
            localparam int BITPOS = (g == 0) ? `RCIL_BIT_TIMER
                                             : `RCIL_BIT_EXT;
            assign clr[g] = wrEn & (idx == `RCIL_IDX_ISTAT)
                          & ~pwdata[BITPOS];
            assign pending[g] = flag[g] & mask_ff[BITPOS];
            rcil_flag uFlag (
                .clk     (clk),
                .rst     (rst),
                .setEvt  (evt[g]),
                .clrEvt  (clr[g]),
                .rstClr  (sysReset),
                .flag_ff (flag[g])
            );
        end
    endgenerate

    // Effective requests to the core
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqRequest_ff <= 2'b00;
        end else begin
            irqRequest_ff <= pending;
        end
    end

    // ==========================================================
    // Global enable and fetch vectoring
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            globalIrqEn_ff <= 1'b0;
            vectorReq_ff   <= 1'b0;
            vectorAddr_ff  <= `RCIL_VEC_IRQ;
        end else if (sysReset) begin
            globalIrqEn_ff <= 1'b0;
            vectorReq_ff   <= 1'b0;
        end else if (vectorReq_ff) begin
            // Held until the core takes the vector
            if (vectorAck) begin
                vectorReq_ff <= 1'b0;
            end
        end else if (globalIrqEn_ff & (|pending)
                     & (mode_ff == rcil_pkg::RCIL_OPER)) begin
            vectorReq_ff   <= 1'b1;
            vectorAddr_ff  <= `RCIL_VEC_IRQ;
            globalIrqEn_ff <= 1'b0;
        end else if (globalIrqEn_ff & instrSoftInt) begin
            vectorReq_ff   <= 1'b1;
            vectorAddr_ff  <= `RCIL_VEC_SOFT;
            globalIrqEn_ff <= 1'b0;
        end else if (instrEni | instrReti) begin
            globalIrqEn_ff <= 1'b1;
        end else if (instrDisi) begin
            globalIrqEn_ff <= 1'b0;
        end
    end

    // ==========================================================
    // APB read mux
    assign istat = {4'h0, flag[1], 2'b00, flag[0]};
    always_comb begin
        rdByte = 8'h00;
        hit    = 1'b1;
        unique case (idx)
            `RCIL_IDX_STATUS: begin
                rdByte[`RCIL_BIT_TOUT] = timeoutFlag_ff;
                rdByte[`RCIL_BIT_PDWN] = powerDownFlag_ff;
            end
            `RCIL_IDX_PORT6:  rdByte = port6Data_ff;
            `RCIL_IDX_PORT7:  rdByte = port7Data_ff;
            `RCIL_IDX_GEN8:   rdByte = gen8_ff;
            `RCIL_IDX_WAKE:   rdByte = wakeEnN_ff;
            `RCIL_IDX_SLPWDT: rdByte = slpWdt_ff;
            `RCIL_IDX_MASK:   rdByte = mask_ff;
            `RCIL_IDX_ISTAT:  rdByte = istat;
            default:          hit    = 1'b0;
        endcase
    end

    // No wait state: ready rises in the first access cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= {24'h00_0000, rdByte};
            pslverr <= psel & ~penable & ~hit;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_oper;
        mode_ff == rcil_pkg::RCIL_OPER;
    endsequence
    sequence s_sleep1;
        mode_ff == rcil_pkg::RCIL_SLEEP1;
    endsequence

    property p_watchdog_clear_instr;
        s_oper and (instrWdtc & ~sysReset)
            |=> timeoutFlag_ff & powerDownFlag_ff;
    endproperty
    a_watchdog_clear_instr: assert property (p_watchdog_clear_instr)
        else $error("clear-watchdog did not set flags");

    property p_pin_oper;
        s_oper and pinEvt |=> $stable(timeoutFlag_ff)
            && $stable(powerDownFlag_ff);
    endproperty
    a_pin_oper: assert property (p_pin_oper)
        else $error("pin reset changed flags");

    property p_pin_s1;
        s_sleep1 and pinEvt |=> timeoutFlag_ff
            && !powerDownFlag_ff ##1 mode_ff == rcil_pkg::RCIL_OPER;
    endproperty
    a_pin_s1: assert property (p_pin_s1)
        else $error("pin wake from sleep one wrong");

    property p_wdt_oper;
        s_oper and (wdtTimeout & ~pinEvt) |=> !timeoutFlag_ff
            && $stable(powerDownFlag_ff);
    endproperty
    a_wdt_oper: assert property (p_wdt_oper)
        else $error("watchdog flags wrong in run mode");

    property p_wdt_s1;
        s_sleep1 and (wdtTimeout & ~pinEvt)
            |=> !timeoutFlag_ff && !powerDownFlag_ff;
    endproperty
    a_wdt_s1: assert property (p_wdt_s1)
        else $error("watchdog wake from sleep one wrong");

    property p_wake2;
        wake2 & ~sysReset |=> slpWdt_ff[`RCIL_BIT_WATCHDOG_ENABLE_BIT]
            && slpWdt_ff[`RCIL_BIT_SLEEP_CONTROL_BIT] && $stable(mask_ff)
            && resumeNext_ff ##1 watchdogRun_ff;
    endproperty
    a_wake2: assert property (p_wake2)
        else $error("pin-change wake did not restore control");

    // Expectation rebuilt from flag and mask, not from the pending net
    property p_mask;
        ##1 irqRequest_ff == ($past(flag)
            & {$past(mask_ff[`RCIL_BIT_EXT]),
               $past(mask_ff[`RCIL_BIT_TIMER])});
    endproperty
    a_mask: assert property (p_mask)
        else $error("request does not follow flag and mask");

    property p_vec;
        ~vectorReq_ff & globalIrqEn_ff & (|pending) & ~sysReset
            & (mode_ff == rcil_pkg::RCIL_OPER) |=> vectorReq_ff
            && vectorAddr_ff == `RCIL_VEC_IRQ && !globalIrqEn_ff;
    endproperty
    a_vec: assert property (p_vec)
        else $error("enabled interrupt not vectored to 001H");

    property p_return_from_irq_instr;
        ~vectorReq_ff & ~sysReset & instrReti & ~instrSoftInt
            & ~(|pending) |=> globalIrqEn_ff;
    endproperty
    a_return_from_irq_instr: assert property (p_return_from_irq_instr)
        else $error("return did not enable interrupts");
endmodule
`default_nettype wire
